// ### verilog/lptc_pkg.sv
/*
 * lptc_pkg: shared constants, types and carriers of the low power ternary codec.
 * assumes: a single pclk domain; apb master and entry port driven by logic on pclk.
 */
`default_nettype none

package lptc_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int ENTRY_W = 80;
	localparam int PAIR_N = ENTRY_W / 2;
	localparam int SB_N = 64;
	localparam int SB_W = 6;
	localparam int EN_W = 32;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_ENABLE = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_MID = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_HI = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_FORMAT = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;

	// field positions of the status word
	localparam int STAT_CNT_LSB = 0;
	localparam int STAT_SB_LSB = 16;
	localparam int STAT_CODED_BIT = 24;

	// reset values
	localparam logic [EN_W-1:0] ENABLE_RST = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic {
		LPTC_FMT_DATA_MASK,
		LPTC_FMT_XY
	} lptc_fmt_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} lptc_apb_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} lptc_apb_rsp_s;

	// word_a is data or x, word_b is mask or y, after write_format_select
	typedef struct packed {
		logic wr;
		logic rd;
		logic [SB_W-1:0] sb;
		logic [ENTRY_W-1:0] word_a;
		logic [ENTRY_W-1:0] word_b;
	} lptc_db_req_s;

	typedef struct packed {
		logic valid;
		logic [ENTRY_W-1:0] x;
		logic [ENTRY_W-1:0] y;
	} lptc_db_rsp_s;

endpackage : lptc_pkg

`default_nettype wire

// ### verilog/lptc_pair_enc.sv
/*
 * lptc_pair_enc: combinational paired-code encoder over all bit pairs of an entry.
 * assumes: caller selects between its output and the raw words.
 */
`default_nettype none

module lptc_pair_enc
	import lptc_pkg::*;
(
	input wire logic [lptc_pkg::ENTRY_W-1:0] word_a,
	input wire logic [lptc_pkg::ENTRY_W-1:0] word_b,
	input wire lptc_pkg::lptc_fmt_e fmt,
	output logic [lptc_pkg::ENTRY_W-1:0] enc_x,
	output logic [lptc_pkg::ENTRY_W-1:0] enc_y
);

	// ----------------------------------------------------------------
	// one pair: odd bit is the upper half, even bit the lower half
	// ----------------------------------------------------------------
	// continuous assigns per bit: one process per slice of a shared vector is refused by some tools
	// every data/mask pair, and every x/y pair without x and y both set, maps onto an allowed stored pattern
	genvar i;
	generate
		for (i = 0; i < PAIR_N; i++) begin : g_pair
			logic a1, a0, b1, b0;
			logic dm;
			assign a1 = word_a[2*i+1];
			assign a0 = word_a[2*i];
			assign b1 = word_b[2*i+1];
			assign b0 = word_b[2*i];
			assign dm = fmt == LPTC_FMT_DATA_MASK;
			assign enc_x[2*i+1] = dm ? ((a1 & ~b1) | (~a0 & ~b0)) : (a1 | b0);
			assign enc_y[2*i+1] = dm ? ((~a1 & ~b1) | (a0 & ~b0)) : (a0 | b1);
			assign enc_x[2*i] = dm ? ((a1 & ~b1) | (a0 & ~b0)) : (a1 | a0);
			assign enc_y[2*i] = dm ? ((~a1 & ~b1) | (~a0 & ~b0)) : (b1 | b0);
		end
	endgenerate

endmodule : lptc_pair_enc

`default_nettype wire

// ### verilog/lptc_entry_store.sv
/*
 * lptc_entry_store: flip-flop store of one x/y entry per superblock, registered read.
 * assumes: at most one write and one read per cycle; a read of the entry being
 * written in the same cycle returns the old contents.
 */
`default_nettype none

module lptc_entry_store
	import lptc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [lptc_pkg::SB_W-1:0] wr_idx,
	input wire logic [lptc_pkg::ENTRY_W-1:0] wr_x,
	input wire logic [lptc_pkg::ENTRY_W-1:0] wr_y,
	input wire logic rd_en,
	input wire logic [lptc_pkg::SB_W-1:0] rd_idx,
	output lptc_pkg::lptc_db_rsp_s rsp
);

	typedef struct packed {
		logic [SB_N-1:0][ENTRY_W-1:0] mem_x;
		logic [SB_N-1:0][ENTRY_W-1:0] mem_y;
		lptc_db_rsp_s rsp;
	} lptc_store_s;

	lptc_store_s s;
	lptc_store_s next_s;

	always_comb begin
		next_s = s;
		next_s.rsp.valid = rd_en;
		if (rd_en) begin
			next_s.rsp.x = s.mem_x[rd_idx];
			next_s.rsp.y = s.mem_y[rd_idx];
		end
		if (wr_en) begin
			next_s.mem_x[wr_idx] = wr_x;
			next_s.mem_y[wr_idx] = wr_y;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rsp = s.rsp;

endmodule : lptc_entry_store

`default_nettype wire

// ### verilog/lptc_codec.sv
/*
 * lptc_codec: low power ternary storage codec with apb control registers.
 * assumes: apb master and entry requester on pclk; software keeps block masks
 * pair-aligned and decodes read data itself.
 */
`default_nettype none

module lptc_codec
	import lptc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire lptc_pkg::lptc_apb_req_s apb_req,
	output lptc_pkg::lptc_apb_rsp_s apb_rsp,
	input wire lptc_pkg::lptc_db_req_s db_req,
	output lptc_pkg::lptc_db_rsp_s db_rsp
);

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	function automatic logic sb_lp_on(input logic [EN_W-1:0] en, input logic [SB_W-1:0] sb);
		sb_lp_on = en[sb[SB_W-1:1]];
	endfunction : sb_lp_on

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		if (a == ADDR_ENABLE || a == ADDR_RSVD_MID || a == ADDR_RSVD_HI) begin
			reg_mapped = 1'b1;
		end else if (a == ADDR_FORMAT || a == ADDR_STATUS) begin
			reg_mapped = 1'b1;
		end else begin
			reg_mapped = 1'b0;
		end
	endfunction : reg_mapped

	function automatic logic [PAIR_N-1:0] odd_bits(input logic [ENTRY_W-1:0] w);
		logic [PAIR_N-1:0] r;
		r = '0;
		for (int k = 0; k < PAIR_N; k++) begin
			r[k] = w[2*k+1];
		end
		odd_bits = r;
	endfunction : odd_bits

	function automatic logic [PAIR_N-1:0] even_bits(input logic [ENTRY_W-1:0] w);
		logic [PAIR_N-1:0] r;
		r = '0;
		for (int k = 0; k < PAIR_N; k++) begin
			r[k] = w[2*k];
		end
		even_bits = r;
	endfunction : even_bits

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [EN_W-1:0] column_saving_enable;
		lptc_fmt_e write_format_select;
		logic [DATA_W-1:0] prdata;
		logic pslverr;
		logic [CNT_W-1:0] coded_count;
		logic [SB_W-1:0] last_sb;
		logic last_coded;
	} lptc_state_s;

	lptc_state_s s;
	lptc_state_s next_s;

	logic setup_phase;
	logic access_wr;
	logic wr_coded;
	logic [ENTRY_W-1:0] enc_x;
	logic [ENTRY_W-1:0] enc_y;
	logic [ENTRY_W-1:0] st_wr_x;
	logic [ENTRY_W-1:0] st_wr_y;

	assign setup_phase = apb_req.psel & ~apb_req.penable;
	assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign wr_coded = sb_lp_on(s.column_saving_enable, db_req.sb);

	// ----------------------------------------------------------------
	// write path
	// ----------------------------------------------------------------
	lptc_pair_enc u_enc (
		.word_a(db_req.word_a),
		.word_b(db_req.word_b),
		.fmt(s.write_format_select),
		.enc_x(enc_x),
		.enc_y(enc_y)
	);

	// uncoded superblocks keep whatever the host wrote, format select ignored
	assign st_wr_x = wr_coded ? enc_x : db_req.word_a;
	assign st_wr_y = wr_coded ? enc_y : db_req.word_b;

	lptc_entry_store u_store (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(db_req.wr),
		.wr_idx(db_req.sb),
		.wr_x(st_wr_x),
		.wr_y(st_wr_y),
		.rd_en(db_req.rd),
		.rd_idx(db_req.sb),
		.rsp(db_rsp)
	);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		// read data is captured in the setup cycle so it can come from a flop
		if (setup_phase) begin
			next_s.pslverr = 1'b0;
			next_s.prdata = DATA_RST;
			if (apb_req.paddr == ADDR_ENABLE) begin
				next_s.prdata = s.column_saving_enable;
			end else if (apb_req.paddr == ADDR_RSVD_MID || apb_req.paddr == ADDR_RSVD_HI) begin
				next_s.prdata = DATA_RST;
			end else if (apb_req.paddr == ADDR_FORMAT) begin
				next_s.prdata[0] = s.write_format_select;
			end else if (apb_req.paddr == ADDR_STATUS) begin
				next_s.prdata[STAT_CNT_LSB +: CNT_W] = s.coded_count;
				next_s.prdata[STAT_SB_LSB +: SB_W] = s.last_sb;
				next_s.prdata[STAT_CODED_BIT] = s.last_coded;
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		if (access_wr) begin
			if (apb_req.paddr == ADDR_ENABLE) begin
				next_s.column_saving_enable = apb_req.pwdata;
			end else if (apb_req.paddr == ADDR_FORMAT) begin
				next_s.write_format_select = lptc_fmt_e'(apb_req.pwdata[0]);
			end
		end
		if (db_req.wr) begin
			next_s.last_sb = db_req.sb;
			next_s.last_coded = wr_coded;
			if (wr_coded) begin
				next_s.coded_count = s.coded_count + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.column_saving_enable <= ENABLE_RST;
			s.write_format_select <= LPTC_FMT_DATA_MASK;
			s.coded_count <= CNT_RST;
		end else begin
			s <= next_s;
		end
	end

	// no wait state: answer in the first access cycle
	assign apb_rsp.pready = apb_req.psel & apb_req.penable;
	assign apb_rsp.prdata = s.prdata;
	assign apb_rsp.pslverr = s.pslverr;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic [PAIR_N-1:0] hx, hy, lx, ly;
	logic [PAIR_N-1:0] bad_pair;
	logic [PAIR_N-1:0] ua1, ua0, ub1, ub0;

	assign hx = odd_bits(st_wr_x);
	assign hy = odd_bits(st_wr_y);
	assign lx = even_bits(st_wr_x);
	assign ly = even_bits(st_wr_y);
	assign ua1 = odd_bits(db_req.word_a);
	assign ua0 = even_bits(db_req.word_a);
	assign ub1 = odd_bits(db_req.word_b);
	assign ub0 = even_bits(db_req.word_b);

	genvar gi;
	generate
		for (gi = 0; gi < PAIR_N; gi++) begin : g_bad
			logic [3:0] pat;
			assign pat = {hx[gi], hy[gi], lx[gi], ly[gi]};
			assign bad_pair[gi] = pat == 4'h1 || pat == 4'h2 || pat == 4'h3 || pat == 4'h4
				|| pat == 4'h8 || pat == 4'hc || pat == 4'hf;
		end
	endgenerate

	a_enable_reset: assert property (@(posedge pclk) $rose(presetn) |-> s.column_saving_enable == '0)
		else $error("enable bits not zero after reset");

	a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
		access_wr && apb_req.paddr == ADDR_ENABLE |=> s.column_saving_enable == $past(apb_req.pwdata))
		else $error("enable write not stored");

	a_enable_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_phase && !apb_req.pwrite && apb_req.paddr == ADDR_ENABLE
		|=> apb_rsp.pready && apb_rsp.prdata == $past(s.column_saving_enable) && !apb_rsp.pslverr)
		else $error("enable read returned wrong value");

	a_dm_roundtrip: assert property (@(posedge pclk) disable iff (!presetn)
		db_req.wr && wr_coded && s.write_format_select == LPTC_FMT_DATA_MASK
		|-> (hx & lx) == (ua1 & ~ub1) && ((~hy & ~lx) | (~hx & ~ly)) == ub1
		&& (hy & lx) == (ua0 & ~ub0) && ((~hx & ~lx) | (~hy & ~ly)) == ub0)
		else $error("data/mask code does not decode back");

	a_xy_roundtrip: assert property (@(posedge pclk) disable iff (!presetn)
		db_req.wr && wr_coded && s.write_format_select == LPTC_FMT_XY && (ua1 & ub1) == '0 && (ua0 & ub0) == '0
		|-> (hx & lx) == ua1 && (hy & ly) == ub1 && (hy & lx) == ua0 && (hx & ly) == ub0)
		else $error("x/y code does not decode back");

	a_no_bad_pair: assert property (@(posedge pclk) disable iff (!presetn)
		db_req.wr && wr_coded && (s.write_format_select == LPTC_FMT_DATA_MASK
		|| ((ua1 & ub1) == '0 && (ua0 & ub0) == '0)) |-> bad_pair == '0)
		else $error("forbidden stored pair pattern");

	a_bypass_raw: assert property (@(posedge pclk) disable iff (!presetn)
		db_req.wr && !wr_coded ##1 db_req.rd && db_req.sb == $past(db_req.sb)
		|=> db_rsp.x == $past(db_req.word_a, 2) && db_rsp.y == $past(db_req.word_b, 2))
		else $error("uncoded entry not returned as written");

	a_read_stored: assert property (@(posedge pclk) disable iff (!presetn)
		db_req.wr ##1 db_req.rd && db_req.sb == $past(db_req.sb)
		|=> db_rsp.valid && db_rsp.x == $past(st_wr_x, 2) && db_rsp.y == $past(st_wr_y, 2))
		else $error("read did not return stored code");

	a_read_latency: assert property (@(posedge pclk) disable iff (!presetn)
		db_req.rd |=> db_rsp.valid)
		else $error("read answer late");

	// a stray valid would pop the host's expectation queue out of step
	a_valid_after_read: assert property (@(posedge pclk) disable iff (!presetn)
		db_rsp.valid |-> $past(db_req.rd))
		else $error("read answer without a read");

	a_fmt_select: assert property (@(posedge pclk) disable iff (!presetn)
		access_wr && apb_req.paddr == ADDR_FORMAT
		|=> s.write_format_select == lptc_fmt_e'($past(apb_req.pwdata[0])))
		else $error("format select not stored");

	// reserved, status and unmapped writes must leave both control fields alone
	a_enable_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(access_wr && apb_req.paddr == ADDR_ENABLE) |=> $stable(s.column_saving_enable))
		else $error("enable bits changed without a write");

	a_fmt_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(access_wr && apb_req.paddr == ADDR_FORMAT) |=> $stable(s.write_format_select))
		else $error("format select changed without a write");

	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		setup_phase && !reg_mapped(apb_req.paddr)
		|=> apb_rsp.pready && apb_rsp.pslverr && apb_rsp.prdata == DATA_RST)
		else $error("unmapped address not refused");

	a_coded_count: assert property (@(posedge pclk) disable iff (!presetn)
		db_req.wr && wr_coded |=> s.coded_count == CNT_W'($past(s.coded_count) + 1'b1))
		else $error("coded write count not advanced");

	// the pair index is the superblock index without its low bit
	a_status_last: assert property (@(posedge pclk) disable iff (!presetn)
		db_req.wr |=> s.last_sb == $past(db_req.sb)
		&& s.last_coded == $past(s.column_saving_enable[db_req.sb[SB_W-1:1]]))
		else $error("status of last write wrong");

	c_dm_coded: cover property (@(posedge pclk) disable iff (!presetn)
		db_req.wr && wr_coded && s.write_format_select == LPTC_FMT_DATA_MASK);
	c_xy_coded: cover property (@(posedge pclk) disable iff (!presetn)
		db_req.wr && wr_coded && s.write_format_select == LPTC_FMT_XY);
	c_bypass: cover property (@(posedge pclk) disable iff (!presetn) db_req.wr && !wr_coded);
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) apb_rsp.pready && apb_rsp.pslverr);

endmodule : lptc_codec

`default_nettype wire

// ### verif/lptc_host_model.sv
/*
 * lptc_host_model: host side of the entry port; issues entry writes and reads
 * and turns paired code back into the words that were written, with each data bit under a set mask bit read back as zero.
 * assumes: one pclk domain; the bench calls put and idle from one process.
 */
`default_nettype none

module lptc_host_model
	import lptc_pkg::*;
(
	input wire logic pclk,
	output var lptc_pkg::lptc_db_req_s db_req
);
	timeunit 1ns;
	timeprecision 1ps;

	// block masks live outside this port and the model never searches, so
	// pair-aligned block masks are kept trivially
	initial begin
		db_req = '0;
	end

	// ----------------------------------------------------------------
	// requests
	// ----------------------------------------------------------------
	task automatic put(input logic w, input logic r, input logic [SB_W-1:0] s,
		input logic [ENTRY_W-1:0] a, input logic [ENTRY_W-1:0] b);
		@(posedge pclk);
		db_req <= '{wr: w, rd: r, sb: s, word_a: a, word_b: b};
	endtask : put

	// idle words flip so nothing stale looks like a valid entry
	task automatic idle();
		@(posedge pclk);
		db_req.wr <= 1'b0;
		db_req.rd <= 1'b0;
		db_req.word_a <= ~db_req.word_a;
		db_req.word_b <= ~db_req.word_b;
	endtask : idle

	// ----------------------------------------------------------------
	// decode of stored pairs, f=0 data/mask, f=1 x/y
	// ----------------------------------------------------------------
	function automatic logic [2*ENTRY_W-1:0] dec(input logic f, input logic [ENTRY_W-1:0] x,
		input logic [ENTRY_W-1:0] y);
		logic [ENTRY_W-1:0] a;
		logic [ENTRY_W-1:0] b;
		int h;
		int l;
		for (int i = 0; i < PAIR_N; i++) begin
			h = 2 * i + 1;
			l = 2 * i;
			a[h] = x[h] & x[l];
			a[l] = y[h] & x[l];
			if (!f) begin
				b[h] = ~y[h] & ~x[l] | ~x[h] & ~y[l];
				b[l] = ~x[h] & ~x[l] | ~y[h] & ~y[l];
			end else begin
				b[h] = y[h] & y[l];
				b[l] = x[h] & y[l];
			end
		end
		return {a, b};
	endfunction : dec

endmodule : lptc_host_model

`default_nettype wire

// ### verif/tb_top.sv
/*
 * tb_top: self-checking bench of lptc_codec; apb register access plus coded
 * and plain entry writes with read-back through the host model.
 * assumes: apb answers with pready; reads answer one cycle after rd.
 */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import lptc_pkg::*;

	typedef struct {
		logic [2*ENTRY_W-1:0] xy;
		logic [2*ENTRY_W-1:0] ab;
		logic dec;
		logic f;
	} lptc_note_s;

	logic pclk;
	logic presetn;
	lptc_apb_req_s apb_req;
	lptc_apb_rsp_s apb_rsp;
	lptc_db_req_s db_req;
	lptc_db_rsp_s db_rsp;
	int num_errors = 0;
	int cmp_count = 0;
	int seed = 32'h17efc68e;
	logic [31:0] en;
	logic fmt;
	lptc_note_s notes[$];
	lptc_note_s nt;
	logic [159:0] dd;
	logic [15:0] ncoded = 16'h0000;
	logic [5:0] lsb = 6'h00;
	logic lon = 1'b0;
	logic [5:0] sbl[6] = '{6'h00, 6'h01, 6'h02, 6'h3d, 6'h3e, 6'h3f};

	lptc_codec i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.db_req(db_req), .db_rsp(db_rsp));
	lptc_host_model i_host (.pclk(pclk), .db_req(db_req));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// checks and expectations
	// ----------------------------------------------------------------
	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk32

	task automatic chk80(input string n, input logic [79:0] e, input logic [79:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk80

	function automatic logic [159:0] enc(input logic on, input logic f, input logic [79:0] a,
		input logic [79:0] b);
		logic [79:0] x;
		logic [79:0] y;
		int h;
		int l;
		x = a;
		y = b;
		for (int i = 0; i < PAIR_N && on; i++) begin
			h = 2 * i + 1;
			l = 2 * i;
			if (!f) begin
				x[h] = a[h] & ~b[h] | ~a[l] & ~b[l];
				y[h] = ~a[h] & ~b[h] | a[l] & ~b[l];
				x[l] = a[h] & ~b[h] | a[l] & ~b[l];
				y[l] = ~a[h] & ~b[h] | ~a[l] & ~b[l];
			end else begin
				x[h] = a[h] | b[l];
				y[h] = a[l] | b[h];
				x[l] = a[h] | a[l];
				y[l] = b[h] | b[l];
			end
		end
		return {x, y};
	endfunction : enc

	function automatic logic [31:0] nbad(input logic [79:0] x, input logic [79:0] y);
		logic [3:0] p;
		nbad = 0;
		for (int i = 0; i < PAIR_N; i++) begin
			p = {x[2*i+1], y[2*i+1], x[2*i], y[2*i]};
			if (p inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc, 4'hf}) nbad++;
		end
	endfunction : nbad

	always @(posedge pclk) begin
		if (db_rsp.valid === 1'b1) begin
			if (notes.size() == 0) begin
				num_errors++;
				$display("BAD valid exp none got 1");
			end else begin
				nt = notes.pop_front();
				chk80("x", nt.xy[159:80], db_rsp.x);
				chk80("y", nt.xy[79:0], db_rsp.y);
				if (nt.dec) begin
					dd = i_host.dec(nt.f, db_rsp.x, db_rsp.y);
					chk80("dec_a", nt.ab[159:80], dd[159:80]);
					chk80("dec_b", nt.ab[79:0], dd[79:0]);
					chk32("forbidden", 32'h0, nbad(db_rsp.x, db_rsp.y));
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// apb master and entry sequences
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
		output logic [31:0] rv, output logic er);
		@(posedge pclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: wd};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		// no wait count assumed here; a hung slave is ended by the watchdog
		do begin
			@(posedge pclk);
		end while (apb_rsp.pready !== 1'b1);
		rv = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	task automatic wrg(input logic [11:0] ad, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, ad, d, r, e);
	endtask : wrg

	task automatic rg(input logic [11:0] ad, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, ad, 32'h0, r, e);
		chk32("reg", x, r);
	endtask : rg

	task automatic entry(input logic [5:0] s);
		logic [79:0] a;
		logic [79:0] b;
		logic on;
		a = 80'({$random(seed), $random(seed), $random(seed)});
		b = 80'({$random(seed), $random(seed), $random(seed)});
		if (fmt) b = b & ~a;
		on = en[s[5:1]];
		lsb = s;
		lon = on;
		ncoded = ncoded + 16'(on);
		notes.push_back('{enc(on, fmt, a, b), fmt ? {a, b} : {a & ~b, b}, on, fmt});
		i_host.put(1'b1, 1'b0, s, a, b);
		i_host.put(1'b0, 1'b1, s, a, b);
		i_host.idle();
	endtask : entry

	task automatic close_out();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	initial begin
		logic [31:0] r;
		logic e;
		presetn = 1'b0;
		apb_req = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rg(ADDR_ENABLE, ENABLE_RST);
		rg(ADDR_FORMAT, 32'h0);
		rg(ADDR_RSVD_MID, 32'h0);
		rg(ADDR_RSVD_HI, 32'h0);
		rg(ADDR_STATUS, 32'h0);
		apb(1'b0, 12'h020, 32'h0, r, e);
		chk32("slverr", 32'h1, {31'h0, e});
		chk32("unmapped_data", 32'h0, r);
		wrg(ADDR_RSVD_MID, 32'hffff_ffff);
		rg(ADDR_RSVD_MID, 32'h0);
		for (int f = 0; f < 2; f++) begin
			fmt = f[0];
			en = 32'h8000_0001;
			wrg(ADDR_FORMAT, 32'(f));
			rg(ADDR_FORMAT, 32'(f));
			wrg(ADDR_ENABLE, en);
			rg(ADDR_ENABLE, en);
			foreach (sbl[k]) entry(sbl[k]);
			for (int k = 0; k < 20; k++) begin
				if (k % 5 == 0) begin
					en = $random(seed);
					wrg(ADDR_ENABLE, en);
					rg(ADDR_ENABLE, en);
				end
				entry(6'($random(seed)));
			end
			r = 32'(ncoded) << STAT_CNT_LSB | 32'(lsb) << STAT_SB_LSB | 32'(lon) << STAT_CODED_BIT;
			rg(ADDR_STATUS, r);
		end
		repeat (4) @(posedge pclk);
		chk32("pending", 32'h0, notes.size());
		// reset in mid-run: registers and stored entries must all return to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rg(ADDR_ENABLE, ENABLE_RST);
		rg(ADDR_FORMAT, 32'h0);
		rg(ADDR_STATUS, 32'h0);
		notes.push_back('{160'h0, 160'h0, 1'b0, 1'b0});
		i_host.put(1'b0, 1'b1, sbl[5], 80'h0, 80'h0);
		i_host.idle();
		repeat (4) @(posedge pclk);
		chk32("pending", 32'h0, notes.size());
		close_out();
	end

	initial begin
		#100000;
		num_errors++;
		close_out();
	end

endmodule : tb_top

`default_nettype wire
